// >>> hw/psr_pin_control.sv
// Purpose: pin state control for ports and external bus across reset and standby
// Assumes: bus state, mode and port settings come from the core on clk;
//          reset, standby and bus request pins are asynchronous
// Notes:   divided system clock falls every other clk; reset is sampled there
//
// Overview of operation
// - Pins that hold state float when inputs and keep their last level when outputs.
// - In single-chip mode 7 the bus is never released.
// - The reset output is driven low only for a watchdog overflow reset, else it floats.
// - A low external reset during an access turns every port pin to input at once.
// - A low external reset drives all four strobes high and floats the data bus at once.
// - In the wide modes 1 to 4, reset in the first, second or wait state drives the address low half a state later.
// - The external reset is sampled on the falling edge of the divided system clock.
// - Reset in a wait state is handled as reset in the second state of a three-state access.
// - Reset in the third state holds the address outputs for the rest of that state.
// - Reset in the second state of a two-state access is handled as in the third state.
module psr_pin_control (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           external_reset_n,
    input  wire logic                           hwStandbyN,
    input  wire logic                           swStandby,
    input  wire logic [psr_pkg::MODE_W-1:0]     opMode,
    input  wire logic [2:0]                     busState,
    input  wire logic                           twoStateArea,
    input  wire logic [psr_pkg::ADDR_W-1:0]     coreAddr,
    input  wire logic [psr_pkg::DATA_W-1:0]     coreData,
    input  wire logic                           coreDataDrive,
    input  wire logic [psr_pkg::STROBE_W-1:0]   coreStrobeN,
    input  wire logic [psr_pkg::PORT_W-1:0]     portDdr,
    input  wire logic [psr_pkg::PORT_W-1:0]     portData,
    input  wire logic                           bus_release_enable,
    input  wire logic                           bus_request_n,
    input  wire logic                           watchdogResetActive,
    output logic                                busRequest,
    output logic                                busReleased,
    output logic                                resetSampledN,
    output logic [psr_pkg::ADDR_W-1:0]          addrOut,
    output logic                                addrOe,
    output logic [psr_pkg::DATA_W-1:0]          dataOut,
    output logic                                dataOe,
    output logic                                address_strobe_n,
    output logic                                readStrobeN,
    output logic                                upper_write_strobe_n,
    output logic                                lower_write_strobe_n,
    output logic                                strobeOe,
    output logic                                busAckOut,
    output logic                                busAckOe,
    output logic [psr_pkg::PORT_W-1:0]          portOut,
    output logic [psr_pkg::PORT_W-1:0]          portOe,
    output logic                                reset_output_n,
    output logic                                resetOutOe
);
    logic [2:0]                           syncIn;
    logic [2:0]                           syncOut;
    logic                                 extResetLow;
    logic                                 hwStandby;
    logic                                 busReqSync;
    logic                                 phiHigh_ff;
    logic                                 phiFall;
    logic                                 resetSampled_ff;
    logic                                 lateCase;
    psr_pkg::psr_addr_e                   addrState_ff;
    psr_pkg::psr_addr_e                   nxt_addrState;
    logic [psr_pkg::HALF_CNT_W-1:0]       halfCnt_ff;
    logic [psr_pkg::ADDR_W-1:0]           addrHold_ff;
    logic [psr_pkg::ADDR_W-1:0]           nxt_addr;
    logic                                 nxt_addrOe;
    logic                                 addrOe_ff;
    logic [psr_pkg::DATA_W-1:0]           dataOut_ff;
    logic                                 dataOe_ff;
    logic [psr_pkg::STROBE_W-1:0]         strobe_ff;
    logic                                 strobeOe_ff;
    logic                                 released_ff;
    logic                                 busAck_ff;
    psr_pkg::psr_pin_cond_e               cond;
    logic                                 portKeep;
    logic                                 portFloat;
    logic [psr_pkg::PORT_W-1:0]           portOeReg;

    function automatic logic isLateState(input logic [2:0] st, input logic twoState);
        isLateState = (st == 3'(psr_pkg::BUS_THIRD)) ||
                      ((st == 3'(psr_pkg::BUS_SECOND)) && twoState);
    endfunction

    function automatic logic wideAddrMode(input logic [psr_pkg::MODE_W-1:0] m);
        wideAddrMode = (m != '0) && (m <= psr_pkg::LAST_WIDE_MODE);
    endfunction

    assign syncIn = {bus_request_n, hwStandbyN, external_reset_n};

    psr_sync #(
        .WIDTH     (3),
        .RESET_VAL (1'h1)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (syncIn),
        .sync_out (syncOut)
    );

    assign extResetLow = ~syncOut[0];
    assign hwStandby   = ~syncOut[1];
    assign busReqSync  = ~syncOut[2];
    assign busRequest  = busReqSync; // request pin is only ever an input

    // divided system clock; phiFall marks the cycle ending its high half
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phiHigh_ff <= 1'b0;
        end else begin
            phiHigh_ff <= ~phiHigh_ff;
        end
    end

    assign phiFall = phiHigh_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resetSampled_ff <= 1'b0;
        end else if (phiFall) begin
            resetSampled_ff <= extResetLow;
        end
    end

    assign resetSampledN = ~resetSampled_ff;

    // wait states fall into the early class with the second state
    assign lateCase = isLateState(busState, twoStateArea);

    always_comb begin
        nxt_addrState = addrState_ff;
        case (addrState_ff)
            psr_pkg::ADR_FOLLOW: begin
                if (phiFall && extResetLow) begin
                    nxt_addrState = lateCase ? psr_pkg::ADR_HOLD_STATE
                                             : psr_pkg::ADR_WAIT_HALF;
                end
            end
            psr_pkg::ADR_WAIT_HALF: begin
                if (halfCnt_ff >= 4'(psr_pkg::HALF_STATE_CLKS - 1)) begin
                    nxt_addrState = psr_pkg::ADR_ZERO;
                end
            end
            psr_pkg::ADR_HOLD_STATE: begin
                // held to the end of the current state, then cleared
                if (halfCnt_ff >= 4'(psr_pkg::HALF_STATE_CLKS - 1)) begin
                    nxt_addrState = psr_pkg::ADR_ZERO;
                end
            end
            psr_pkg::ADR_ZERO: begin
                if (!extResetLow && !resetSampled_ff) begin
                    nxt_addrState = psr_pkg::ADR_FOLLOW;
                end
            end
            default: begin
                nxt_addrState = psr_pkg::ADR_FOLLOW;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addrState_ff <= psr_pkg::ADR_ZERO;
        end else begin
            addrState_ff <= nxt_addrState;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halfCnt_ff <= '0;
        end else if (addrState_ff != nxt_addrState) begin
            halfCnt_ff <= '0;
        end else if (halfCnt_ff != '1) begin
            halfCnt_ff <= halfCnt_ff + 4'h1;
        end
    end

    // pin condition, highest priority first
    always_comb begin
        if (hwStandby) begin
            cond = psr_pkg::PIN_HW_STANDBY;
        end else if (extResetLow || resetSampled_ff) begin
            cond = psr_pkg::PIN_RESET;
        end else if (released_ff) begin
            cond = psr_pkg::PIN_RELEASED;
        end else if (swStandby) begin
            cond = psr_pkg::PIN_SW_STANDBY;
        end else begin
            cond = psr_pkg::PIN_RUN;
        end
    end

    // bus release never granted in single-chip mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            released_ff <= 1'b0;
        end else begin
            released_ff <= bus_release_enable && busReqSync && !extResetLow
                           && !hwStandby && (opMode != psr_pkg::SINGLE_CHIP_MODE);
        end
    end

    assign busReleased = released_ff;

    always_comb begin
        nxt_addr   = addrHold_ff;
        nxt_addrOe = 1'b0;
        case (cond)
            psr_pkg::PIN_RUN: begin
                nxt_addr   = coreAddr;
                nxt_addrOe = wideAddrMode(opMode) || (opMode != psr_pkg::SINGLE_CHIP_MODE);
            end
            psr_pkg::PIN_RESET: begin
                nxt_addrOe = wideAddrMode(opMode);
                if (addrState_ff == psr_pkg::ADR_ZERO) begin
                    nxt_addr = psr_pkg::ADDR_RESET_VAL;
                end else if (addrState_ff == psr_pkg::ADR_FOLLOW) begin
                    nxt_addr = coreAddr;
                end
            end
            default: begin
                // released, standby: address floats
                nxt_addrOe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addrHold_ff <= psr_pkg::ADDR_RESET_VAL;
            addrOe_ff   <= 1'b0;
        end else begin
            addrHold_ff <= nxt_addr; // hold state keeps old value
            addrOe_ff   <= nxt_addrOe;
        end
    end

    assign addrOut = addrHold_ff;
    // hardware standby floats the address at once, like the other bus pins
    assign addrOe  = addrOe_ff && !hwStandby;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dataOut_ff  <= '0;
            dataOe_ff   <= 1'b0;
            strobe_ff   <= psr_pkg::STROBE_RESET_VAL;
            strobeOe_ff <= 1'b0;
        end else begin
            dataOut_ff  <= coreData;
            dataOe_ff   <= (cond == psr_pkg::PIN_RUN) && coreDataDrive;
            strobe_ff   <= (cond == psr_pkg::PIN_RUN) ? coreStrobeN : psr_pkg::STROBE_IDLE;
            strobeOe_ff <= (cond == psr_pkg::PIN_RUN || cond == psr_pkg::PIN_RESET)
                           && (opMode != psr_pkg::SINGLE_CHIP_MODE);
        end
    end

    // reset level gates the registered bus outputs without waiting a cycle
    assign dataOut              = dataOut_ff;
    assign dataOe               = dataOe_ff && !extResetLow && !hwStandby;
    assign address_strobe_n     = strobe_ff[3] | extResetLow;
    assign readStrobeN          = strobe_ff[2] | extResetLow;
    assign upper_write_strobe_n = strobe_ff[1] | extResetLow;
    assign lower_write_strobe_n = strobe_ff[0] | extResetLow;
    assign strobeOe             = strobeOe_ff && !hwStandby && !released_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busAck_ff <= 1'b0;
        end else begin
            busAck_ff <= (cond == psr_pkg::PIN_RELEASED);
        end
    end

    assign busAckOut = 1'b0;
    assign busAckOe  = busAck_ff && !hwStandby;

    assign portKeep  = (cond == psr_pkg::PIN_SW_STANDBY) || (cond == psr_pkg::PIN_RELEASED);
    assign portFloat = (cond == psr_pkg::PIN_RESET) || (cond == psr_pkg::PIN_HW_STANDBY);

    psr_pin_group #(
        .WIDTH (psr_pkg::PORT_W)
    ) u_port (
        .clk      (clk),
        .rst      (rst),
        .driveEn  (portDdr),
        .driveVal (portData),
        .keepReq  (portKeep),
        .floatReq (portFloat),
        .pinOut   (portOut),
        .pinOe    (portOeReg)
    );

    // reset turns the port to input in the same cycle it is seen
    assign portOe = extResetLow || hwStandby ? '0 : portOeReg;

    // open drain: only a watchdog caused reset pulls the pin low
    assign reset_output_n = 1'b0;
    assign resetOutOe     = watchdogResetActive && !hwStandby;
endmodule

// >>> hw/psr_pkg.sv
// Purpose: shared constants and types for the pin state and reset control block
// Assumes: 50 MHz clk; the bus state clock is clk divided by two
// Notes:   widths are fixed at the device pin counts
package psr_pkg;
    localparam int ADDR_W        = 24;
    localparam int DATA_W        = 16;
    localparam int PORT_W        = 8;
    localparam int STROBE_W      = 4;
    localparam int MODE_W        = 3;
    localparam int CLK_PERIOD_NS = 20;
    // one bus state is one period of the divided system clock
    localparam int STATE_NS      = 40;
    localparam int HALF_STATE_NS = STATE_NS / 2;
    // longest wait rounds down, never below one cycle
    localparam int HALF_STATE_CLKS = (HALF_STATE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                     (HALF_STATE_NS / CLK_PERIOD_NS);
    localparam int HALF_CNT_W    = 4;
    localparam logic [MODE_W-1:0]   SINGLE_CHIP_MODE = 3'h7;
    localparam logic [MODE_W-1:0]   LAST_WIDE_MODE   = 3'h4;
    localparam logic [ADDR_W-1:0]   ADDR_RESET_VAL   = 24'h000000;
    localparam logic [STROBE_W-1:0] STROBE_IDLE      = 4'hF;
    localparam logic [STROBE_W-1:0] STROBE_RESET_VAL = 4'hF;

    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_FIRST,
        BUS_SECOND,
        BUS_THIRD,
        BUS_WAIT
    } psr_bus_state_e;

    typedef enum logic [2:0] {
        PIN_RUN,
        PIN_RESET,
        PIN_HW_STANDBY,
        PIN_SW_STANDBY,
        PIN_RELEASED
    } psr_pin_cond_e;

    typedef enum {
        ADR_FOLLOW,
        ADR_WAIT_HALF,
        ADR_HOLD_STATE,
        ADR_ZERO
    } psr_addr_e;
endpackage

// >>> hw/psr_sync.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs arrive from outside the clk domain
// Notes:   first stage is read only by the second stage
module psr_sync #(
    parameter int         WIDTH    = 1,
    parameter logic [0:0] RESET_VAL = 1'h1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff  <= {WIDTH{RESET_VAL}};
            sync_out <= {WIDTH{RESET_VAL}};
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// >>> hw/psr_pin_group.sv
// Purpose: output register for a group of pins with drive, keep and float requests
// Assumes: requests come from logic on clk
// Notes:   float wins over keep, keep wins over drive
module psr_pin_group #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] driveEn,
    input  wire logic [WIDTH-1:0] driveVal,
    input  wire logic             keepReq,
    input  wire logic             floatReq,
    output logic      [WIDTH-1:0] pinOut,
    output logic      [WIDTH-1:0] pinOe
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinOut <= '0;
            pinOe  <= '0;
        end else if (floatReq) begin
            pinOe  <= '0;
        end else if (keepReq) begin
            // inputs stay floating, outputs keep their last level
            pinOut <= pinOut;
            pinOe  <= pinOe;
        end else begin
            pinOut <= driveVal;
            pinOe  <= driveEn;
        end
    end
endmodule

// >>> sim/psr_pin_checker.sv
// Purpose: port-level checks for the pin state control block
// Assumes: one clk domain, rst async high, pin inputs pass a 2-FF sync
// Notes:   antecedents hold pins a few cycles to cover the sync delay
module psr_pin_checker (
    input wire logic                         clk,
    input wire logic                         rst,
    input wire logic                         external_reset_n,
    input wire logic                         hwStandbyN,
    input wire logic                         swStandby,
    input wire logic [psr_pkg::MODE_W-1:0]   opMode,
    input wire logic                         bus_release_enable,
    input wire logic                         bus_request_n,
    input wire logic                         watchdogResetActive,
    input wire logic                         busReleased,
    input wire logic                         resetSampledN,
    input wire logic [psr_pkg::ADDR_W-1:0]   addrOut,
    input wire logic                         addrOe,
    input wire logic                         dataOe,
    input wire logic                         address_strobe_n,
    input wire logic                         readStrobeN,
    input wire logic                         upper_write_strobe_n,
    input wire logic                         lower_write_strobe_n,
    input wire logic                         strobeOe,
    input wire logic                         busAckOut,
    input wire logic                         busAckOe,
    input wire logic [psr_pkg::PORT_W-1:0]   portOut,
    input wire logic [psr_pkg::PORT_W-1:0]   portOe,
    input wire logic                         reset_output_n,
    input wire logic                         resetOutOe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_reset_held;
        (!external_reset_n && hwStandbyN)[*3];
    endsequence
    // address is only driven low in the wide modes
    sequence s_reset_long;
        (!external_reset_n && hwStandbyN && opMode != 3'h0
         && opMode <= psr_pkg::LAST_WIDE_MODE)[*7];
    endsequence
    sequence s_request_held;
        (!bus_request_n && bus_release_enable && external_reset_n && hwStandbyN
         && opMode != psr_pkg::SINGLE_CHIP_MODE)[*5];
    endsequence
    property p_port_input;
        s_reset_held |-> portOe == '0 && !dataOe;
    endproperty
    property p_strobe_high;
        s_reset_held |-> {address_strobe_n, readStrobeN, upper_write_strobe_n,
                          lower_write_strobe_n} == psr_pkg::STROBE_RESET_VAL;
    endproperty
    property p_addr_low;
        s_reset_long |-> addrOut == '0 && addrOe;
    endproperty
    property p_sample_cause;
        $fell(resetSampledN) |-> !$past(external_reset_n, 2);
    endproperty
    property p_sample_bound;
        (!external_reset_n && hwStandbyN)[*6] |-> !resetSampledN;
    endproperty
    // once reset is taken the address may only hold or clear
    property p_hold_addr;
        (!resetSampledN && !$past(resetSampledN)) |-> addrOut == '0 || $stable(addrOut);
    endproperty
    property p_watchdog_out;
        (watchdogResetActive && hwStandbyN)[*4] |-> resetOutOe && !reset_output_n;
    endproperty
    property p_no_watchdog;
        !watchdogResetActive |-> !resetOutOe;
    endproperty
    property p_hw_float;
        (!hwStandbyN)[*3] |-> portOe == '0 && !addrOe && !dataOe && !strobeOe
                              && !busAckOe && !resetOutOe;
    endproperty
    property p_mode7;
        (opMode == psr_pkg::SINGLE_CHIP_MODE)[*3] |-> !busReleased && !busAckOe;
    endproperty
    property p_release;
        s_request_held |-> busAckOe && !busAckOut && !addrOe && !dataOe && !strobeOe;
    endproperty
    property p_keep;
        (swStandby && external_reset_n && hwStandbyN && bus_request_n)[*4]
            |-> $stable(portOe) && $stable(portOut);
    endproperty
    a_port_input: assert property (p_port_input)
        else $error("ports not input during reset");
    a_strobe_high: assert property (p_strobe_high)
        else $error("strobes not high during reset");
    a_addr_low: assert property (p_addr_low)
        else $error("address not driven low in reset");
    a_sample_cause: assert property (p_sample_cause)
        else $error("reset taken without low pin");
    a_sample_bound: assert property (p_sample_bound)
        else $error("low reset pin not taken");
    a_hold_addr: assert property (p_hold_addr)
        else $error("address moved during reset");
    a_watchdog_out: assert property (p_watchdog_out)
        else $error("reset output not driven low");
    a_no_watchdog: assert property (p_no_watchdog)
        else $error("reset output driven without watchdog");
    a_hw_float: assert property (p_hw_float)
        else $error("pin driven in hardware standby");
    a_mode7: assert property (p_mode7)
        else $error("bus released in single chip mode");
    a_release: assert property (p_release)
        else $error("bus release pins wrong");
    a_keep: assert property (p_keep)
        else $error("port pins not kept in standby");
endmodule

bind psr_pin_control psr_pin_checker psr_pin_checker_i (
    .clk(clk), .rst(rst), .external_reset_n(external_reset_n), .hwStandbyN(hwStandbyN),
    .swStandby(swStandby), .opMode(opMode), .bus_release_enable(bus_release_enable),
    .bus_request_n(bus_request_n), .watchdogResetActive(watchdogResetActive),
    .busReleased(busReleased), .resetSampledN(resetSampledN), .addrOut(addrOut),
    .addrOe(addrOe), .dataOe(dataOe), .address_strobe_n(address_strobe_n),
    .readStrobeN(readStrobeN), .upper_write_strobe_n(upper_write_strobe_n),
    .lower_write_strobe_n(lower_write_strobe_n), .strobeOe(strobeOe),
    .busAckOut(busAckOut), .busAckOe(busAckOe), .portOut(portOut), .portOe(portOe),
    .reset_output_n(reset_output_n), .resetOutOe(resetOutOe));

// >>> sim/psr_bus_peer.sv
// Purpose: external bus master that asks for the bus
// Assumes: request pin has a pull-up, so released means high
// Notes:   changes only just after a rising edge
module psr_bus_peer (
    input  wire logic clk,
    input  wire logic wantBus,
    output logic      bus_request_n
);
    timeunit 1ns;
    timeprecision 100ps;
    initial bus_request_n = 1'b1;
    always @(posedge clk) begin
        bus_request_n <= #1 !wantBus;
    end
endmodule

// >>> sim/tb_pin_state_reset_control.sv
// Purpose: directed bench for the pin state control block
// Assumes: 50 MHz clk, inputs change 1 ns after the rising edge
// Notes:   each scenario task drives and judges on its own
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR %s exp %0h got %0h", nm, exp, got); end end
module tb_pin_state_reset_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 0, rst = 1, external_reset_n = 1, hwStandbyN = 1, swStandby = 0;
    logic        twoStateArea = 0, coreDataDrive = 0, bus_release_enable = 0;
    logic        watchdogResetActive = 0, wantBus = 0, bus_request_n;
    logic [2:0]  opMode = 3'h2, busState = 3'h0;
    logic [23:0] coreAddr = 24'h000000, addrOut;
    logic [15:0] coreData = 16'h0000, dataOut;
    logic [3:0]  coreStrobeN = 4'hF;
    logic [7:0]  portDdr = 8'h00, portData = 8'h00, portOut, portOe;
    logic        busRequest, busReleased, resetSampledN, addrOe, dataOe, strobeOe;
    logic        address_strobe_n, readStrobeN, upper_write_strobe_n, lower_write_strobe_n;
    logic        busAckOut, busAckOe, reset_output_n, resetOutOe;
    int          n_fail = 0, checks_done = 0;
    logic [3:0]  strobesN;
    assign strobesN = {address_strobe_n, readStrobeN, upper_write_strobe_n, lower_write_strobe_n};
    psr_pin_control psr_pin_control_i (
        .clk(clk), .rst(rst), .external_reset_n(external_reset_n), .hwStandbyN(hwStandbyN),
        .swStandby(swStandby), .opMode(opMode), .busState(busState),
        .twoStateArea(twoStateArea), .coreAddr(coreAddr), .coreData(coreData),
        .coreDataDrive(coreDataDrive), .coreStrobeN(coreStrobeN), .portDdr(portDdr),
        .portData(portData), .bus_release_enable(bus_release_enable),
        .bus_request_n(bus_request_n), .watchdogResetActive(watchdogResetActive),
        .busRequest(busRequest), .busReleased(busReleased), .resetSampledN(resetSampledN),
        .addrOut(addrOut), .addrOe(addrOe), .dataOut(dataOut), .dataOe(dataOe),
        .address_strobe_n(address_strobe_n), .readStrobeN(readStrobeN),
        .upper_write_strobe_n(upper_write_strobe_n),
        .lower_write_strobe_n(lower_write_strobe_n), .strobeOe(strobeOe),
        .busAckOut(busAckOut), .busAckOe(busAckOe), .portOut(portOut), .portOe(portOe),
        .reset_output_n(reset_output_n), .resetOutOe(resetOutOe));
    psr_bus_peer psr_bus_peer_i (.clk(clk), .wantBus(wantBus), .bus_request_n(bus_request_n));
    always #10 clk = ~clk;
    task summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wait_sampled(logic lvl);
        int i;
        for (i = 0; i < 20 && resetSampledN !== lvl; i++) step(1);
        if (resetSampledN !== lvl) begin
            n_fail++;
            summarize();
        end
    endtask
    // reset pin dropped in mid-access with the core still driving
    task t_reset(logic [2:0] st, logic two, logic hold);
        busState = st;
        twoStateArea = two;
        step(2);
        external_reset_n = 0;
        step(3);
        `CHK("portOe", 8'h00, portOe)
        `CHK("dataOe", 1'b0, dataOe)
        `CHK("strobes", 4'hF, strobesN)
        wait_sampled(1'b0);
        if (hold) `CHK("addrHeld", 24'h123456, addrOut)
        step(3);
        `CHK("addrOut", 24'h000000, addrOut)
        `CHK("addrOe", 1'b1, addrOe)
        external_reset_n = 1;
        wait_sampled(1'b1);
        step(4);
    endtask
    // held long enough for the checker to see a watchdog reset in force
    task t_watchdog();
        watchdogResetActive = 1;
        step(4);
        `CHK("resetOutOe", 1'b1, resetOutOe)
        `CHK("reset_output_n", 1'b0, reset_output_n)
        watchdogResetActive = 0;
        step(1);
        `CHK("resetOutOe", 1'b0, resetOutOe)
    endtask
    task t_hw();
        watchdogResetActive = 1;
        hwStandbyN = 0;
        step(4);
        `CHK("allOe", 12'h000, {portOe, addrOe, dataOe, strobeOe, resetOutOe})
        hwStandbyN = 1;
        watchdogResetActive = 0;
        step(6);
    endtask
    task t_release(logic [2:0] mode);
        int i;
        opMode = mode;
        bus_release_enable = 1;
        wantBus = 1;
        step(2);
        if (mode == 3'h7) begin
            step(10);
            `CHK("busReleased", 1'b0, busReleased)
            `CHK("busAckOe", 1'b0, busAckOe)
        end else begin
            for (i = 0; i < 10 && busAckOe !== 1'b1; i++) step(1);
            `CHK("busRequest", 1'b1, busRequest)
            `CHK("busReleased", 1'b1, busReleased)
            `CHK("busAckOe", 1'b1, busAckOe)
            `CHK("relPins", 4'h0, {addrOe, dataOe, strobeOe, busAckOut})
        end
        wantBus = 0;
        step(8);
        opMode = 3'h2;
    endtask
    // core values move during standby; pins must not
    task t_sw();
        busState = 3'h0;
        portDdr = 8'h0F;
        portData = 8'h5A;
        step(2);
        swStandby = 1;
        step(2);
        portData = 8'hC3;
        portDdr = 8'hFF;
        step(3);
        `CHK("portOe", 8'h0F, portOe)
        `CHK("portOut", 4'hA, portOut[3:0])
        swStandby = 0;
        step(2);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst = 0;
        portDdr = 8'hFF;
        portData = 8'hA5;
        coreAddr = 24'h123456;
        coreData = 16'hBEEF;
        coreDataDrive = 1;
        coreStrobeN = 4'h0;
        step(4);
        `CHK("dataOut", 16'hBEEF, dataOut)
        `CHK("dataOeRun", 1'b1, dataOe)
        `CHK("strobesRun", 4'h0, strobesN)
        t_reset(3'h1, 1'b0, 1'b0);
        t_reset(3'h2, 1'b0, 1'b0);
        t_reset(3'h4, 1'b0, 1'b0);
        t_reset(3'h3, 1'b0, 1'b1);
        t_reset(3'h2, 1'b1, 1'b1);
        t_watchdog();
        t_hw();
        t_release(3'h2);
        t_release(3'h7);
        t_sw();
        summarize();
    end
endmodule
